// *** src/uamb_pkg.sv ***
// Purpose: Shared constants and types for the serial port register slice.
// Assumes: APB word access; each register index maps to byte address index*4.
package uamb_pkg;

  localparam int unsigned APB_AW = 10;

  // Register indices; byte address is the index times four
  localparam logic [7:0] IDX_AUX = 8'h87;
  localparam logic [7:0] IDX_RELOAD = 8'h8d;
  localparam logic [7:0] IDX_PCON = 8'h97;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] IDX_SLAVE_ADDRESS = 8'ha9;
  localparam logic [7:0] IDX_SLAVE_ADDRESS_MASK = 8'hb9;

  // Power/baud control fields
  localparam int unsigned PCON_DBL = 7;
  localparam int unsigned PCON_FES = 6;
  localparam logic [7:0] PCON_RST = 8'h10;
  localparam logic [7:0] PCON_RW_MASK = 8'hdf;

  // Auxiliary clock select fields
  localparam int unsigned AUX_T1FAST = 6;
  localparam int unsigned AUX_M0FAST = 5;
  localparam logic [7:0] AUX_RST = 8'h00;
  localparam logic [7:0] AUX_RW_MASK = 8'he3;
  localparam logic [7:0] AUX_RSV_VAL = 8'h00;

  // Serial control fields
  localparam int unsigned SC_M0 = 7;
  localparam int unsigned SC_M1 = 6;
  localparam int unsigned SC_ARE = 5;
  localparam int unsigned SC_REN = 4;
  localparam int unsigned SC_TB8 = 3;
  localparam int unsigned SC_TI = 1;
  localparam int unsigned SC_RI = 0;

  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] RELOAD_RST = 8'h00;

  // Divider counts
  localparam logic [3:0] T1_PRE_LAST = 4'h0b;
  // Mode 0 ticks mark half bits, so a bit of 12 or 2 clocks needs 6 or 1
  localparam logic [3:0] M0_SLOW_LAST = 4'h5;
  localparam logic [3:0] M0_FAST_LAST = 4'h0;
  localparam logic [1:0] M2_SLOW_LAST = 2'h3;
  localparam logic [1:0] M2_FAST_LAST = 2'h1;
  localparam logic [3:0] OS_LAST = 4'h0f;
  localparam logic [3:0] OS_MID = 4'h07;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } uamb_rx_state_t;

  typedef struct packed {
    logic [1:0] mode;
    logic dbl;
    logic t1_fast;
    logic m0_fast;
    logic [7:0] reload;
  } uamb_baud_cfg_t;

  typedef struct packed {
    logic os_tick;
    logic m0_tick;
  } uamb_tick_t;

endpackage

// *** src/uamb_baud_gen.sv ***
// Purpose: Baud tick generator: 16x oversample tick and mode 0 shift tick.
// Assumes: Timer 1 runs as an 8-bit auto-reload timer.
// Notes: Ticks are one-cycle pulses, registered.
`timescale 1ns/1ps
module uamb_baud_gen
  import uamb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire uamb_baud_cfg_t cfg,
  output uamb_tick_t tick
);
  logic [3:0] pre;
  logic [7:0] t1;
  logic half;
  logic [1:0] m2;
  logic [3:0] m0;
  wire logic t1_en = cfg.t1_fast | (pre == T1_PRE_LAST);
  wire logic t1_ovf = t1_en & (t1 == 8'hff);
  wire logic [1:0] m2_last = cfg.dbl ? M2_FAST_LAST : M2_SLOW_LAST;
  wire logic [3:0] m0_last = cfg.m0_fast ? M0_FAST_LAST : M0_SLOW_LAST;
  wire logic os_t1 = t1_ovf & (cfg.dbl | half);
  wire logic os_m2 = (m2 == m2_last);
  wire logic os_sel = (cfg.mode == 2'd2) ? os_m2 : os_t1;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pre <= 4'h0;
      t1 <= 8'h00;
      half <= 1'b0;
      m2 <= 2'h0;
      m0 <= 4'h0;
      tick <= '0;
    end
    else
    begin
      pre <= (pre == T1_PRE_LAST) ? 4'h0 : pre + 4'h1;
      if (t1_en)
        t1 <= t1_ovf ? cfg.reload : t1 + 8'h01;
      if (t1_ovf)
        half <= ~half;
      m2 <= os_m2 ? 2'h0 : m2 + 2'h1;
      m0 <= (m0 >= m0_last) ? 4'h0 : m0 + 4'h1;
      tick.os_tick <= (cfg.mode != 2'd0) & os_sel;
      tick.m0_tick <= (cfg.mode == 2'd0) & (m0 >= m0_last);
    end
  end
endmodule // uamb_baud_gen

// *** src/uamb_uart_core.sv ***
// Purpose: Serial port register slice with address recognition and baud control.
// Assumes: APB slave with no wait states; rx_pin is asynchronous.
// Notes: Mode 0 is transmit only here; reception runs in modes 1 to 3.
`timescale 1ns/1ps
module uamb_uart_core
  import uamb_pkg::*;
#(
  parameter int unsigned ADDR_W = APB_AW
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic shift_clk
);

  // Register state
  logic [7:0] slave_address;
  logic [7:0] slave_address_mask;
  logic [7:0] serial_buffer;
  logic [7:0] pcon_store;
  logic [7:0] aux_store;
  logic [7:0] baud_reload;
  logic mode_bit_zero;
  logic mode_bit_one;
  logic address_recognition_enable;
  logic rx_enable;
  logic tx_ninth;
  logic rx_ninth;
  logic transmit_flag;
  logic receive_flag;
  logic frame_error_flag;

  // Decode
  wire logic [ADDR_W-1:0] a_aux = ADDR_W'({IDX_AUX, 2'b00});
  wire logic [ADDR_W-1:0] a_reload = ADDR_W'({IDX_RELOAD, 2'b00});
  wire logic [ADDR_W-1:0] a_pcon = ADDR_W'({IDX_PCON, 2'b00});
  wire logic [ADDR_W-1:0] a_serial_control = ADDR_W'({IDX_SERIAL_CONTROL, 2'b00});
  wire logic [ADDR_W-1:0] a_serial_buffer = ADDR_W'({IDX_SERIAL_BUFFER, 2'b00});
  wire logic [ADDR_W-1:0] a_slave_address = ADDR_W'({IDX_SLAVE_ADDRESS, 2'b00});
  wire logic [ADDR_W-1:0] a_slave_address_mask = ADDR_W'({IDX_SLAVE_ADDRESS_MASK, 2'b00});
  wire logic sel_aux = (paddr == a_aux);
  wire logic sel_reload = (paddr == a_reload);
  wire logic sel_pcon = (paddr == a_pcon);
  wire logic sel_serial_control = (paddr == a_serial_control);
  wire logic sel_serial_buffer = (paddr == a_serial_buffer);
  wire logic sel_slave_address = (paddr == a_slave_address);
  wire logic sel_slave_address_mask = (paddr == a_slave_address_mask);
  wire logic hit = sel_aux | sel_reload | sel_pcon | sel_serial_control | sel_serial_buffer
    | sel_slave_address | sel_slave_address_mask;
  wire logic setup = psel & ~penable;
  // Writes land only in the access cycle that completes
  wire logic wr = psel & penable & pready & pwrite & pstrb[0] & ~pslverr;
  wire logic [7:0] wd = pwdata[7:0];

  wire logic dbl = pcon_store[PCON_DBL];
  wire logic fes = pcon_store[PCON_FES];
  wire logic [1:0] mode = {mode_bit_zero, mode_bit_one};
  wire logic nine_bit = mode_bit_zero;
  wire logic [7:0] pcon_rd = pcon_store & PCON_RW_MASK;
  // Reserved bits read a fixed value, never the stored one
  wire logic [7:0] aux_rd = (aux_store & AUX_RW_MASK) | (AUX_RSV_VAL & ~AUX_RW_MASK);
  wire logic serial_control_top = fes ? frame_error_flag : mode_bit_zero;
  wire logic [7:0] serial_control_rd = {serial_control_top, mode_bit_one, address_recognition_enable,
    rx_enable, tx_ninth, rx_ninth, transmit_flag, receive_flag};
  wire logic [7:0] rd_mux = sel_aux ? aux_rd
    : sel_reload ? baud_reload
    : sel_pcon ? pcon_rd
    : sel_serial_control ? serial_control_rd
    : sel_serial_buffer ? serial_buffer
    : sel_slave_address ? slave_address
    : sel_slave_address_mask ? slave_address_mask
    : 8'h00;

  // APB answer: registered, ready in the first access cycle after setup, no wait state
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup)
        prdata <= {24'h00_0000, rd_mux};
    end
  end

  // Baud generation
  uamb_baud_cfg_t cfg;
  uamb_tick_t tick;
  assign cfg.mode = mode;
  assign cfg.dbl = dbl;
  assign cfg.t1_fast = aux_store[AUX_T1FAST];
  assign cfg.m0_fast = aux_store[AUX_M0FAST];
  assign cfg.reload = baud_reload;

  uamb_baud_gen u_baud (
    .clk(clk),
    .rst_b(rst_b),
    .cfg(cfg),
    .tick(tick)
  );

  // Receive pin synchroniser
  logic rx_meta;
  logic rx_s;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_meta <= 1'b1;
      rx_s <= 1'b1;
    end
    else
    begin
      rx_meta <= rx_pin;
      rx_s <= rx_meta;
    end
  end

  // Receive state machine
  uamb_rx_state_t rx_state;
  uamb_rx_state_t next_rx_state;
  logic [3:0] rx_os;
  logic [3:0] rx_bits;
  logic [8:0] rx_sh;
  wire logic [3:0] rx_nbits = nine_bit ? 4'd9 : 4'd8;
  wire logic rx_sample_end = tick.os_tick & (rx_os == OS_LAST);
  wire logic rx_mid = tick.os_tick & (rx_os == OS_MID);

  always_comb
  begin
    next_rx_state = rx_state;
    unique case (rx_state)
      RX_IDLE:
        if (rx_enable & (mode != 2'd0) & ~rx_s & tick.os_tick)
          next_rx_state = RX_START;
      RX_START:
        if (rx_mid)
          next_rx_state = rx_s ? RX_IDLE : RX_DATA;
      RX_DATA:
        if (rx_sample_end & (rx_bits == rx_nbits - 4'd1))
          next_rx_state = RX_STOP;
      RX_STOP:
        if (rx_sample_end)
          next_rx_state = RX_IDLE;
      default:
        next_rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_state <= RX_IDLE;
      rx_os <= 4'h0;
      rx_bits <= 4'h0;
      rx_sh <= 9'h000;
    end
    else
    begin
      rx_state <= next_rx_state;
      if (rx_state == RX_IDLE | (rx_state == RX_START & rx_mid))
        rx_os <= 4'h0;
      else if (tick.os_tick)
        rx_os <= rx_os + 4'h1;
      if (rx_state == RX_IDLE)
        rx_bits <= 4'h0;
      else if (rx_state == RX_DATA & rx_sample_end)
      begin
        rx_bits <= rx_bits + 4'h1;
        rx_sh <= {rx_s, rx_sh[8:1]};
      end
    end
  end

  // End of reception, sampled halfway through the stop bit
  wire logic rx_done = (rx_state == RX_STOP) & rx_sample_end;
  wire logic stop_ok = rx_s;
  wire logic [7:0] rx_byte = nine_bit ? rx_sh[7:0] : rx_sh[8:1];
  wire logic rx_bit9 = rx_sh[8];
  // Don't-care where the mask bit is zero
  wire logic given_hit = ((rx_byte ^ slave_address) & slave_address_mask) == 8'h00;
  wire logic [7:0] bcast = slave_address | slave_address_mask;
  wire logic bcast_hit = ((rx_byte ^ bcast) & bcast) == 8'h00;
  // All-zero masks after reset make both tests pass for any byte
  wire logic addr_hit = given_hit | bcast_hit;
  wire logic gate_nine = rx_bit9 & addr_hit;
  wire logic gate_one = stop_ok & addr_hit;
  wire logic gate = ~address_recognition_enable
    | (nine_bit ? gate_nine : gate_one);
  wire logic rx_accept = rx_done & ~receive_flag & gate;
  wire logic fe_set = rx_done & ~stop_ok;

  // Transmit shifter
  logic [10:0] tx_sh;
  logic [3:0] tx_left;
  logic [3:0] tx_os;
  wire logic tx_busy = (tx_left != 4'h0);
  wire logic m0 = (mode == 2'd0);
  wire logic tx_tick = m0 ? tick.m0_tick : tick.os_tick;
  wire logic [3:0] tx_os_last = m0 ? 4'h1 : OS_LAST;
  wire logic tx_bit_end = tx_busy & tx_tick & (tx_os == tx_os_last);
  wire logic [3:0] next_tx_os = ~tx_busy ? 4'h0
    : tx_bit_end ? 4'h0
    : tx_tick ? tx_os + 4'h1
    : tx_os;
  logic [7:0] serial_buffer_next;
  wire logic tx_start = wr & sel_serial_buffer & ~tx_busy;
  wire logic [10:0] tx_frame = m0 ? {3'b111, serial_buffer_next}
    : {1'b1, (nine_bit ? tx_ninth : 1'b1), serial_buffer_next, 1'b0};
  wire logic [3:0] tx_len = m0 ? 4'd8 : (nine_bit ? 4'd11 : 4'd10);
  // Flag at end of 8th shift in mode 0, start of stop bit otherwise
  wire logic ti_set = tx_bit_end & (tx_left == (m0 ? 4'd1 : 4'd2));

  // Single holding byte: a write stages transmit, a reception overwrites unless a write lands in the same cycle
  always_comb
  begin
    serial_buffer_next = serial_buffer;
    if (rx_accept)
      serial_buffer_next = rx_byte;
    if (wr & sel_serial_buffer)
      serial_buffer_next = wd;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      tx_sh <= 11'h7ff;
      tx_left <= 4'h0;
      tx_os <= 4'h0;
      tx_pin <= 1'b1;
      shift_clk <= 1'b1;
    end
    else
    begin
      tx_os <= next_tx_os;
      if (tx_start)
      begin
        tx_sh <= tx_frame;
        tx_left <= tx_len;
        tx_pin <= tx_frame[0];
      end
      else if (tx_bit_end)
      begin
        tx_sh <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'h1;
        tx_pin <= (tx_left > 4'h1) ? tx_sh[1] : 1'b1;
      end
      // Mode 0 clock idles high, low in first half of each bit
      shift_clk <= ~(m0 & (tx_busy | tx_start)) | next_tx_os[0];
    end
  end

  // Software registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      slave_address <= ADDR_RST;
      slave_address_mask <= ADDR_RST;
      serial_buffer <= 8'h00;
      pcon_store <= PCON_RST;
      aux_store <= AUX_RST;
      baud_reload <= RELOAD_RST;
    end
    else
    begin
      serial_buffer <= serial_buffer_next;
      if (wr & sel_slave_address)
        slave_address <= wd;
      if (wr & sel_slave_address_mask)
        slave_address_mask <= wd;
      if (wr & sel_pcon)
        pcon_store <= wd & PCON_RW_MASK;
      if (wr & sel_aux)
        aux_store <= wd & AUX_RW_MASK;
      if (wr & sel_reload)
        baud_reload <= wd;
    end
  end

  // Serial control; hardware sets win over a clearing write
  wire logic sc_wr = wr & sel_serial_control;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mode_bit_zero <= 1'b0;
      mode_bit_one <= 1'b0;
      address_recognition_enable <= 1'b0;
      rx_enable <= 1'b0;
      tx_ninth <= 1'b0;
      rx_ninth <= 1'b0;
      transmit_flag <= 1'b0;
      receive_flag <= 1'b0;
      frame_error_flag <= 1'b0;
    end
    else
    begin
      if (sc_wr)
      begin
        if (!fes)
          mode_bit_zero <= wd[SC_M0];
        mode_bit_one <= wd[SC_M1];
        address_recognition_enable <= wd[SC_ARE];
        rx_enable <= wd[SC_REN];
        tx_ninth <= wd[SC_TB8];
      end
      if (rx_accept)
        rx_ninth <= nine_bit ? rx_bit9 : stop_ok;
      else if (sc_wr)
        rx_ninth <= wd[2];
      if (ti_set)
        transmit_flag <= 1'b1;
      else if (sc_wr)
        transmit_flag <= wd[SC_TI];
      if (rx_accept)
        receive_flag <= 1'b1;
      else if (sc_wr)
        receive_flag <= wd[SC_RI];
      if (fe_set)
        frame_error_flag <= 1'b1;
      else if (sc_wr & fes)
        frame_error_flag <= wd[SC_M0];
    end
  end

endmodule // uamb_uart_core

// *** testbench/uamb_uart_chk.sv ***
// Purpose: Port-level checks for the serial port register slice.
// Assumes: Shadows follow APB writes, so address, mask, clock select and baud control reads can be judged.
// Notes: Mode 0 clock checks use the shadowed fast-select bit.
`timescale 1ns/1ps
module uamb_uart_chk
  import uamb_pkg::*;
#(
  parameter int unsigned ADDR_W = APB_AW
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic shift_clk
);
  logic [7:0] sh_sa;
  logic [7:0] sh_sm;
  logic [7:0] sh_aux;
  logic [1:0] sh_pc;
  logic [3:0] hi_run;
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite && pstrb[0];
  wire rd = acc && !pwrite;
  wire [7:0] idx = 8'(paddr >> 2);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sh_sa <= 8'h00;
      sh_sm <= 8'h00;
      sh_aux <= 8'h00;
      sh_pc <= 2'b00;
    end
    else if (wr)
    begin
      if (idx == IDX_SLAVE_ADDRESS) sh_sa <= pwdata[7:0];
      if (idx == IDX_SLAVE_ADDRESS_MASK) sh_sm <= pwdata[7:0];
      if (idx == IDX_AUX) sh_aux <= pwdata[7:0];
      if (idx == IDX_PCON) sh_pc <= pwdata[7:6];
    end
  end

  // First low of a frame starts off the free-running divider, so in the slow setting
  // only lows that follow a full high half-bit are timed; the fast check times every low
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      hi_run <= 4'h0;
    else if (shift_clk)
      hi_run <= (hi_run == 4'hf) ? 4'hf : hi_run + 4'h1;
    else
      hi_run <= 4'h0;
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_RDY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_SLAVE_ADDRESS_RD: assert property (rd && idx == IDX_SLAVE_ADDRESS |-> prdata[7:0] == sh_sa)
    else $error("slave address readback off");
  AST_SLAVE_ADDRESS_MASK_RD: assert property (rd && idx == IDX_SLAVE_ADDRESS_MASK |-> prdata[7:0] == sh_sm)
    else $error("mask readback off");
  AST_AUX_RD: assert property (rd && idx == IDX_AUX |-> prdata[6:5] == sh_aux[6:5])
    else $error("clock select readback off");
  AST_AUX_RSV: assert property (rd && idx == IDX_AUX |-> prdata[4:2] == 3'b000)
    else $error("reserved bits not constant");
  AST_PCON_RD: assert property (rd && idx == IDX_PCON |-> prdata[7:5] == {sh_pc, 1'b0})
    else $error("baud control readback off");
  AST_M0_SLOW: assert property ($fell(shift_clk) && !sh_aux[5] && hi_run == 4'h6
    |-> !shift_clk [*6] ##1 shift_clk)
    else $error("slow shift clock half period off");
  AST_M0_FAST: assert property ($fell(shift_clk) && sh_aux[5] |=> shift_clk)
    else $error("fast shift clock half period off");
endmodule // uamb_uart_chk

bind uamb_uart_core uamb_uart_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .shift_clk(shift_clk));

// *** testbench/uamb_node_model.sv ***
// Purpose: Remote node on the multidrop line, sending frames to the slice.
// Assumes: Bit time is given in system clocks for each frame.
// Notes: Line idles high between frames, as a UART line does.
`timescale 1ns/1ps
module uamb_node_model
(
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;

  // Start bit, data LSB first, then stop; a stop of 0 makes a frame error
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input int bt);
    for (int i = 0; i < nb + 2; i++)
    begin
      @(posedge clk);
      line <= (i == 0) ? 1'b0 : (i > nb) ? stop : d[i-1];
      repeat (bt - 1) @(posedge clk);
    end
    @(posedge clk);
    line <= 1'b1;
    repeat (bt) @(posedge clk);
  endtask
endmodule // uamb_node_model

// *** testbench/uart_addr_match_baud_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for the serial port register slice.
// Assumes: Remote node model drives the receive line.
// Notes: Mode 0 has no reception, so it is judged on the first transmit bit and the shift clock.
`timescale 1ns/1ps
module uart_addr_match_baud_ctrl_tb_top
  import uamb_pkg::*;
;
  logic clk;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_pin;
  logic tx_pin;
  logic shift_clk;
  int error_cnt;
  int total_checks;
  int bt;
  logic m1;
  logic e;
  logic [7:0] q, sa, sm, sc;
  logic [7:0] ri [4];

  uamb_uart_core u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .shift_clk(shift_clk));
  uamb_node_model u_node (.clk(clk), .line(rx_pin));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      error_cnt++;
      wrap_up();
    end
    @(posedge clk);
  endtask

  function automatic logic hit(input logic [7:0] b);
    logic [7:0] bc;
    bc = sa | sm;
    return (((b ^ sa) & sm) == 8'h00) || (((b ^ bc) & bc) == 8'h00);
  endfunction

  task automatic rx_case(input logic [7:0] b, input logic nth, input logic stop);
    logic x;
    x = (m1 ? stop : nth) & hit(b);
    u_node.send({nth, b}, m1 ? 8 : 9, stop, bt);
    apb(1'b0, IDX_SERIAL_CONTROL, 8'h00);
    chk(8'(q[0]), 8'(x));
    if (x)
    begin
      apb(1'b0, IDX_SERIAL_BUFFER, 8'h00);
      chk(q, b);
    end
    apb(1'b1, IDX_SERIAL_CONTROL, sc);
  endtask

  task automatic m0(input logic [7:0] aux, input int exp);
    int k;
    logic [7:0] d;
    d = 8'($urandom);
    apb(1'b1, IDX_AUX, aux);
    apb(1'b1, IDX_SERIAL_BUFFER, d);
    chk(8'(tx_pin), 8'(d[0]));
    // Skip the first low, which the free-running divider may shorten
    k = 0;
    while (shift_clk !== 1'b1 && k < 64)
    begin
      @(posedge clk);
      k++;
    end
    k = 0;
    while (shift_clk !== 1'b0 && k < 64)
    begin
      @(posedge clk);
      k++;
    end
    while (shift_clk !== 1'b1 && k < 64)
    begin
      @(posedge clk);
      k++;
    end
    chk(8'(k), 8'(exp));
    repeat (300) @(posedge clk);
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'h93fc9ed4));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    ri = '{IDX_AUX, IDX_SLAVE_ADDRESS, IDX_SLAVE_ADDRESS_MASK, IDX_PCON};
    foreach (ri[i])
    begin
      apb(1'b0, ri[i], 8'h00);
      chk(q, (ri[i] == IDX_PCON) ? PCON_RST : AUX_RST);
    end
    apb(1'b1, IDX_AUX, 8'hff);
    apb(1'b0, IDX_AUX, 8'h00);
    chk(q, AUX_RW_MASK);
    apb(1'b1, IDX_PCON, 8'hff);
    apb(1'b0, IDX_PCON, 8'h00);
    chk(q, PCON_RW_MASK);
    apb(1'b0, 8'h00, 8'h00);
    chk(8'(e), 8'h01);
    pstrb <= 4'h0;
    apb(1'b1, IDX_SLAVE_ADDRESS, 8'h5a);
    pstrb <= 4'hf;
    apb(1'b0, IDX_SLAVE_ADDRESS, 8'h00);
    chk(q, ADDR_RST);
    $display("test registers done");
    // Mode 2 plain, mode 2 doubled, mode 1 on the fast timer
    for (int c = 0; c < 3; c++)
    begin
      m1 = (c == 2);
      bt = (c == 0) ? 64 : 32;
      sc = m1 ? 8'h70 : 8'hb0;
      sa = 8'hc0;
      sm = 8'hfd;
      apb(1'b1, IDX_PCON, (c == 1) ? 8'h90 : 8'h10);
      apb(1'b1, IDX_AUX, m1 ? 8'h40 : 8'h00);
      apb(1'b1, IDX_RELOAD, 8'hff);
      apb(1'b1, IDX_SERIAL_CONTROL, sc);
      apb(1'b1, IDX_SLAVE_ADDRESS, sa);
      apb(1'b1, IDX_SLAVE_ADDRESS_MASK, sm);
      rx_case(8'hc2, 1'b1, 1'b1);
      rx_case(8'hc1, 1'b1, 1'b1);
      rx_case(8'hff, 1'b1, 1'b1);
      rx_case(8'hc0, 1'b0, !m1);
      for (int r = 0; r < 2; r++)
      begin
        sa = 8'($urandom);
        sm = 8'($urandom);
        apb(1'b1, IDX_SLAVE_ADDRESS, sa);
        apb(1'b1, IDX_SLAVE_ADDRESS_MASK, sm);
        apb(1'b0, IDX_SLAVE_ADDRESS_MASK, 8'h00);
        chk(q, sm);
        rx_case(sa ^ (8'($urandom) & ~sm), 1'b1, 1'b1);
        rx_case(8'($urandom), 1'($urandom), 1'b1);
      end
      $display("test reception config %0d done", c);
    end
    apb(1'b0, IDX_SERIAL_CONTROL, 8'h00);
    chk(8'(q[7]), 8'h00);
    apb(1'b1, IDX_PCON, 8'h50);
    apb(1'b0, IDX_SERIAL_CONTROL, 8'h00);
    chk(8'(q[7]), 8'h01);
    apb(1'b1, IDX_SERIAL_CONTROL, 8'h00);
    apb(1'b0, IDX_SERIAL_CONTROL, 8'h00);
    chk(8'(q[7]), 8'h00);
    apb(1'b1, IDX_PCON, 8'h10);
    apb(1'b1, IDX_SERIAL_CONTROL, 8'h00);
    $display("test frame error done");
    m0(8'h00, 12);
    m0(8'h20, 2);
    $display("test shift clock done");
    wrap_up();
  end
endmodule // uart_addr_match_baud_ctrl_tb_top
